// ---- boot_exec_cfg.svh ----
// Constants of the boot command executor: codes, offsets, field positions and reset values.
`ifndef BOOT_EXEC_CFG_SVH
`define BOOT_EXEC_CFG_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_ERASE_ALL_UNLOCK 8'h0D
`define CMD_MEM_STORE 8'h04
`define CMD_KEY_UNLOCK 8'h06
`define CMD_EXECUTE 8'h0E
`define CMD_RESET 8'h0B
`define PCNT_ERASE_ALL_UNLOCK 8'h00
`define PCNT_MEM_STORE 8'h02
`define PCNT_KEY_UNLOCK 8'h02
`define PCNT_EXECUTE 8'h03
`define PCNT_RESET 8'h00
`define PARAM_BYTES 10'h00C

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define ST_OK 32'h0000_0000
`define ST_FLASH_ALIGN 32'h0000_0065
`define ST_FLASH_PROTECT 32'h0000_0068
`define ST_FLASH_FAIL 32'h0000_0069
`define ST_INVALID_ARG 32'h0000_0004
`define ST_UNKNOWN_CMD 32'h0000_2710

// ----------------------------------------------------------------
// Flash layout and security
// ----------------------------------------------------------------
`define FLASH_LIMIT 32'h0000_8000
`define SECTOR_LSB 10
`define SECTOR_MSB 14
`define KEY_LOCATION 32'h0000_0400
`define SECURITY_LOCATION 32'h0000_040C
`define SECURITY_WORD 32'hFFFF_FFFE
`define MASS_ERASE_LSB 4
`define MASS_ERASE_MSB 5
`define MASS_ERASE_OFF 2'h2
`define ERASED_WORD 32'hFFFF_FFFF

// ----------------------------------------------------------------
// Exit state values
// ----------------------------------------------------------------
`define VECTOR_OFFSET_RESET 32'h0000_0000
`define SERIAL_CLOCK_SELECT 2'h3

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_REMAIN 8'h08
`define CTRL_VERIFY_BIT 0
`define CTRL_HIGH_SPEED_BIT 1
`define CTRL_RESET 2'h1
`define STAT_BUSY_BIT 16
`define STAT_SECURE_OPEN_BIT 17

`endif

// ---- boot_exec_pkg.sv ----
// Types shared by the boot command executor and its lane collector.
package boot_exec_pkg;

	typedef enum logic [1:0] {FL_ERASE_ALL, FL_PROGRAM, FL_VERIFY} flash_op_t;

	typedef enum {S_HEADER, S_PARAMS, S_DISPATCH, S_ERASE, S_SECURE_WR, S_DATA, S_PROG, S_VERIFY,
		S_RAM, S_REPLY, S_EXIT} exec_state_t;

	typedef enum logic [1:0] {AF_NONE, AF_EXIT, AF_RESET} after_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_in_t;

	typedef struct packed {
		logic valid;
		logic [7:0] command_code;
		logic [31:0] status;
	} generic_reply_t;

	typedef struct packed {
		logic valid;
		flash_op_t op;
		logic [31:0] addr;
		logic [31:0] data;
	} flash_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [7:0] data;
	} ram_req_t;

	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic [31:0] arg;
		logic [31:0] sp;
	} jump_t;

	typedef struct packed {
		logic restore_pulse;
		logic two_wire_ctrl_restore;
		logic four_wire_ctrl_restore;
		logic irq_disable;
		logic keep_high_speed;
		logic port_a_clock_gate;
		logic port_b_clock_gate;
		logic [1:0] serial_clock_select;
		logic [31:0] vector_table_offset;
	} exit_ctrl_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic [31:0] word;
	} lane_state_t;

	typedef struct packed {
		exec_state_t st;
		after_t after;
		logic [31:0] header;
		logic [95:0] params;
		logic [9:0] bcnt;
		logic [31:0] addr;
		logic [31:0] transfer_length;
		logic is_flash;
		generic_reply_t reply;
		flash_req_t flash;
		ram_req_t ram;
		jump_t jump;
		exit_ctrl_t exit_ctrl;
		logic verify_after_program;
		logic high_speed_select;
		logic secure_open;
		logic boot_seen;
		logic very_low_power_run_leave;
		logic chip_reset;
		logic wb_ack;
		logic [31:0] wb_dat;
	} exec_regs_t;

endpackage

// ---- boot_flash_command_executor.sv ----
// Command executor of the boot loader: parses command packets, drives flash and RAM, replies, exits.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "boot_exec_cfg.svh"
module boot_flash_command_executor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire boot_exec_pkg::byte_in_t cmd_in,
	output logic cmd_ready,
	output boot_exec_pkg::generic_reply_t reply,
	input wire logic reply_ready,
	output boot_exec_pkg::flash_req_t flash_req,
	input wire logic flash_done,
	input wire logic flash_fail,
	input wire logic [7:0] security_byte,
	input wire logic [63:0] backdoor_key,
	input wire logic [31:0] sector_protect,
	output boot_exec_pkg::ram_req_t ram_req,
	input wire logic ram_ack,
	input wire logic detect_timeout,
	input wire logic [31:0] app_entry,
	input wire logic [31:0] app_stack,
	input wire logic very_low_power_run,
	output logic very_low_power_run_leave,
	output boot_exec_pkg::jump_t jump,
	output boot_exec_pkg::exit_ctrl_t exit_ctrl,
	output logic chip_reset_req,
	output logic secure_open
);
	boot_exec_pkg::exec_regs_t s;
	boot_exec_pkg::exec_regs_t next_s;

	logic coll_clear;
	logic coll_push;
	logic [31:0] coll_word;
	logic [2:0] coll_cnt;
	logic coll_full;
	logic do_reply;
	logic [31:0] rep_status;
	logic byte_take;
	logic [7:0] cmd_code;
	logic [7:0] pcount;
	logic [31:0] p0;
	logic [31:0] p1;
	logic [31:0] p2;
	logic [31:0] last_byte;
	logic prot_hit;
	logic word_due;
	logic wb_hit;

	word_lane_collector lanes (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clear(coll_clear),
		.push(coll_push),
		.data_in(cmd_in.data),
		.word(coll_word),
		.count(coll_cnt),
		.full(coll_full)
	);

	// ----------------------------------------------------------------
	// Decoded fields
	// ----------------------------------------------------------------
	assign cmd_code = s.header[7:0];
	assign pcount = s.header[31:24];
	assign p0 = s.params[31:0];
	assign p1 = s.params[63:32];
	assign p2 = s.params[95:64];
	assign last_byte = p0 + p1 - 32'h0000_0001;
	// Both ends of the range are checked; a range wider than one sector in between is not.
	assign prot_hit = sector_protect[p0[`SECTOR_MSB:`SECTOR_LSB]] | sector_protect[last_byte[`SECTOR_MSB:`SECTOR_LSB]];
	assign word_due = coll_full || (s.transfer_length == 32'h0000_0000 && coll_cnt != 3'h0);
	assign byte_take = cmd_ready && cmd_in.valid;
	assign wb_hit = wb_cyc_i && wb_stb_i;

	always_comb begin
		cmd_ready = 1'b0;
		unique case (s.st)
			boot_exec_pkg::S_HEADER, boot_exec_pkg::S_PARAMS: begin
				cmd_ready = 1'b1;
			end
			boot_exec_pkg::S_DATA: begin
				cmd_ready = !(s.is_flash && word_due) && s.transfer_length != 32'h0000_0000;
			end
			default: begin
				cmd_ready = 1'b0;
			end
		endcase
	end

	assign coll_push = byte_take && s.st == boot_exec_pkg::S_DATA && s.is_flash;

	// ----------------------------------------------------------------
	// Command sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		do_reply = 1'b0;
		rep_status = `ST_OK;
		coll_clear = 1'b0;
		next_s.jump.valid = 1'b0;
		next_s.chip_reset = 1'b0;
		next_s.very_low_power_run_leave = 1'b0;
		next_s.exit_ctrl.restore_pulse = 1'b0;
		next_s.exit_ctrl.two_wire_ctrl_restore = 1'b0;
		next_s.exit_ctrl.four_wire_ctrl_restore = 1'b0;
		if (!s.boot_seen) begin
			next_s.boot_seen = 1'b1;
			next_s.very_low_power_run_leave = very_low_power_run;
		end
		unique case (s.st)
			boot_exec_pkg::S_HEADER: begin
				if (byte_take) begin
					next_s.header[s.bcnt[1:0]*8 +: 8] = cmd_in.data;
					next_s.bcnt = s.bcnt + 10'h001;
					if (s.bcnt == 10'h003) begin
						next_s.bcnt = 10'h000;
						next_s.params = '0;
						next_s.st = (cmd_in.data == 8'h00) ? boot_exec_pkg::S_DISPATCH : boot_exec_pkg::S_PARAMS;
					end
				end else if (detect_timeout && s.bcnt == 10'h000) begin
					next_s.jump.pc = app_entry;
					next_s.jump.arg = 32'h0000_0000;
					next_s.jump.sp = app_stack;
					next_s.st = boot_exec_pkg::S_EXIT;
				end
			end
			boot_exec_pkg::S_PARAMS: begin
				if (byte_take) begin
					if (s.bcnt < `PARAM_BYTES) begin
						next_s.params[s.bcnt[3:0]*8 +: 8] = cmd_in.data;
					end
					next_s.bcnt = s.bcnt + 10'h001;
					if (s.bcnt == {pcount, 2'b00} - 10'h001) begin
						next_s.bcnt = 10'h000;
						next_s.st = boot_exec_pkg::S_DISPATCH;
					end
				end
			end
			boot_exec_pkg::S_DISPATCH: begin
				next_s.after = boot_exec_pkg::AF_NONE;
				do_reply = 1'b1;
				case (cmd_code)
					`CMD_ERASE_ALL_UNLOCK: begin
						if (pcount != `PCNT_ERASE_ALL_UNLOCK) begin
							rep_status = `ST_INVALID_ARG;
						end else if (security_byte[`MASS_ERASE_MSB:`MASS_ERASE_LSB] == `MASS_ERASE_OFF) begin
							rep_status = `ST_FLASH_FAIL;
						end else begin
							do_reply = 1'b0;
							next_s.flash = '{valid: 1'b1, op: boot_exec_pkg::FL_ERASE_ALL, addr: 32'h0000_0000,
								data: `ERASED_WORD};
							next_s.st = boot_exec_pkg::S_ERASE;
						end
					end
					`CMD_MEM_STORE: begin
						next_s.addr = p0;
						next_s.transfer_length = p1;
						next_s.is_flash = p0 < `FLASH_LIMIT;
						if (pcount != `PCNT_MEM_STORE) begin
							rep_status = `ST_INVALID_ARG;
						end else if (p0 < `FLASH_LIMIT && p0[1:0] != 2'b00) begin
							rep_status = `ST_FLASH_ALIGN;
						end else if (p0 < `FLASH_LIMIT && p1 != 32'h0000_0000 && prot_hit) begin
							rep_status = `ST_FLASH_PROTECT;
						end else if (p1 != 32'h0000_0000) begin
							do_reply = 1'b0;
							coll_clear = 1'b1;
							next_s.st = boot_exec_pkg::S_DATA;
						end
					end
					`CMD_KEY_UNLOCK: begin
						if (pcount != `PCNT_KEY_UNLOCK) begin
							rep_status = `ST_INVALID_ARG;
						end else if ({p1, p0} == backdoor_key) begin
							next_s.secure_open = 1'b1;
						end else begin
							rep_status = `ST_FLASH_FAIL;
						end
					end
					`CMD_EXECUTE: begin
						if (pcount != `PCNT_EXECUTE || p2[1:0] != 2'b00) begin
							rep_status = `ST_INVALID_ARG;
						end else begin
							next_s.jump.pc = p0;
							next_s.jump.arg = p1;
							next_s.jump.sp = p2;
							next_s.after = boot_exec_pkg::AF_EXIT;
						end
					end
					`CMD_RESET: begin
						if (pcount != `PCNT_RESET) begin
							rep_status = `ST_INVALID_ARG;
						end else begin
							next_s.after = boot_exec_pkg::AF_RESET;
						end
					end
					default: begin
						rep_status = `ST_UNKNOWN_CMD;
					end
				endcase
			end
			boot_exec_pkg::S_ERASE: begin
				if (flash_done) begin
					if (flash_fail) begin
						next_s.flash.valid = 1'b0;
						do_reply = 1'b1;
						rep_status = `ST_FLASH_FAIL;
					end else begin
						next_s.secure_open = 1'b1;
						next_s.flash = '{valid: 1'b1, op: boot_exec_pkg::FL_PROGRAM, addr: `SECURITY_LOCATION,
							data: `SECURITY_WORD};
						next_s.st = boot_exec_pkg::S_SECURE_WR;
					end
				end
			end
			boot_exec_pkg::S_SECURE_WR: begin
				if (flash_done) begin
					next_s.flash.valid = 1'b0;
					do_reply = 1'b1;
					rep_status = flash_fail ? `ST_FLASH_FAIL : `ST_OK;
				end
			end
			boot_exec_pkg::S_DATA: begin
				if (s.is_flash && word_due) begin
					next_s.flash = '{valid: 1'b1, op: boot_exec_pkg::FL_PROGRAM, addr: s.addr, data: coll_word};
					next_s.st = boot_exec_pkg::S_PROG;
				end else if (byte_take) begin
					next_s.transfer_length = s.transfer_length - 32'h0000_0001;
					if (!s.is_flash) begin
						next_s.ram = '{valid: 1'b1, addr: s.addr, data: cmd_in.data};
						next_s.addr = s.addr + 32'h0000_0001;
						next_s.st = boot_exec_pkg::S_RAM;
					end
				end
			end
			boot_exec_pkg::S_PROG, boot_exec_pkg::S_VERIFY: begin
				if (flash_done) begin
					next_s.flash.valid = 1'b0;
					if (flash_fail) begin
						do_reply = 1'b1;
						rep_status = `ST_FLASH_FAIL;
					end else if (s.st == boot_exec_pkg::S_PROG && s.verify_after_program) begin
						next_s.flash.valid = 1'b1;
						next_s.flash.op = boot_exec_pkg::FL_VERIFY;
						next_s.st = boot_exec_pkg::S_VERIFY;
					end else begin
						coll_clear = 1'b1;
						next_s.addr = s.addr + 32'h0000_0004;
						if (s.transfer_length == 32'h0000_0000) begin
							do_reply = 1'b1;
						end else begin
							next_s.st = boot_exec_pkg::S_DATA;
						end
					end
				end
			end
			boot_exec_pkg::S_RAM: begin
				if (ram_ack) begin
					next_s.ram.valid = 1'b0;
					if (s.transfer_length == 32'h0000_0000) begin
						do_reply = 1'b1;
					end else begin
						next_s.st = boot_exec_pkg::S_DATA;
					end
				end
			end
			boot_exec_pkg::S_REPLY: begin
				if (reply_ready) begin
					next_s.reply.valid = 1'b0;
					next_s.st = boot_exec_pkg::S_HEADER;
					if (s.after == boot_exec_pkg::AF_EXIT) begin
						next_s.st = boot_exec_pkg::S_EXIT;
					end else if (s.after == boot_exec_pkg::AF_RESET) begin
						next_s.chip_reset = 1'b1;
					end
				end
			end
			boot_exec_pkg::S_EXIT: begin
				// The serial controls and the vector table offset are put back and interrupts disabled; pin muxing and the low power serial port stay.
				next_s.exit_ctrl.restore_pulse = 1'b1;
				next_s.exit_ctrl.two_wire_ctrl_restore = 1'b1;
				next_s.exit_ctrl.four_wire_ctrl_restore = 1'b1;
				next_s.exit_ctrl.irq_disable = 1'b1;
				next_s.exit_ctrl.vector_table_offset = `VECTOR_OFFSET_RESET;
				next_s.exit_ctrl.keep_high_speed = s.high_speed_select;
				next_s.exit_ctrl.port_a_clock_gate = 1'b1;
				next_s.exit_ctrl.port_b_clock_gate = 1'b1;
				next_s.exit_ctrl.serial_clock_select = `SERIAL_CLOCK_SELECT;
				next_s.jump.valid = 1'b1;
				next_s.st = boot_exec_pkg::S_HEADER;
			end
		endcase
		if (do_reply) begin
			next_s.reply = '{valid: 1'b1, command_code: cmd_code, status: rep_status};
			next_s.st = boot_exec_pkg::S_REPLY;
		end

		// ----------------------------------------------------------------
		// Wishbone slave
		// ----------------------------------------------------------------
		next_s.wb_ack = wb_hit && !s.wb_ack;
		next_s.wb_dat = 32'h0000_0000;
		if (wb_hit && !s.wb_ack && !wb_we_i) begin
			case (wb_adr_i[7:0])
				`REG_CONTROL: begin
					next_s.wb_dat[`CTRL_VERIFY_BIT] = s.verify_after_program;
					next_s.wb_dat[`CTRL_HIGH_SPEED_BIT] = s.high_speed_select;
				end
				`REG_STATUS: begin
					next_s.wb_dat[15:0] = s.reply.status[15:0];
					next_s.wb_dat[`STAT_BUSY_BIT] = s.st != boot_exec_pkg::S_HEADER || s.bcnt != 10'h000;
					next_s.wb_dat[`STAT_SECURE_OPEN_BIT] = s.secure_open;
				end
				`REG_REMAIN: begin
					next_s.wb_dat = s.transfer_length;
				end
				default: begin
					next_s.wb_dat = 32'h0000_0000;
				end
			endcase
		end
		// A write lands on the edge at which ack is seen high, so the master and the register agree.
		if (wb_hit && s.wb_ack && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == `REG_CONTROL) begin
			next_s.verify_after_program = wb_dat_i[`CTRL_VERIFY_BIT];
			next_s.high_speed_select = wb_dat_i[`CTRL_HIGH_SPEED_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.st <= boot_exec_pkg::S_HEADER;
			s.after <= boot_exec_pkg::AF_NONE;
			s.flash.op <= boot_exec_pkg::FL_ERASE_ALL;
			s.verify_after_program <= 1'(`CTRL_RESET);
			s.exit_ctrl.port_a_clock_gate <= 1'b1;
			s.exit_ctrl.port_b_clock_gate <= 1'b1;
			s.exit_ctrl.serial_clock_select <= `SERIAL_CLOCK_SELECT;
			s.exit_ctrl.vector_table_offset <= `VECTOR_OFFSET_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign wb_dat_o = s.wb_dat;
	assign wb_ack_o = s.wb_ack;
	assign reply = s.reply;
	assign flash_req = s.flash;
	assign ram_req = s.ram;
	assign jump = s.jump;
	assign exit_ctrl = s.exit_ctrl;
	assign chip_reset_req = s.chip_reset;
	assign secure_open = s.secure_open;
	assign very_low_power_run_leave = s.very_low_power_run_leave;
endmodule

// ---- boot_flash_command_executor_checker.sv ----
// Checker of port timing relations and port value rules (flash word alignment, kept exit controls) of the boot command executor.
`timescale 1ns/1ns
`include "boot_exec_cfg.svh"
module boot_exec_checker (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire boot_exec_pkg::generic_reply_t reply,
	input wire logic reply_ready,
	input wire boot_exec_pkg::flash_req_t flash_req,
	input wire logic flash_done,
	input wire boot_exec_pkg::jump_t jump,
	input wire boot_exec_pkg::exit_ctrl_t exit_ctrl,
	input wire logic chip_reset_req,
	input wire logic very_low_power_run,
	input wire logic very_low_power_run_leave
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not one cycle after request");
	AST_WB_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");
	AST_REPLY_HOLD: assert property (reply.valid && !reply_ready |=> reply.valid && $stable(reply))
		else $error("reply dropped or changed before accept");
	AST_RESET_AFTER_REPLY: assert property (chip_reset_req |-> $past(reply.valid && reply_ready &&
		reply.command_code == `CMD_RESET && reply.status == `ST_OK))
		else $error("chip reset without accepted ok reply");
	AST_JUMP_EXIT: assert property (jump.valid |->
		exit_ctrl.restore_pulse && exit_ctrl.irq_disable &&
		exit_ctrl.two_wire_ctrl_restore && exit_ctrl.four_wire_ctrl_restore &&
		exit_ctrl.vector_table_offset == `VECTOR_OFFSET_RESET)
		else $error("jump without exit restore");
	AST_EXIT_KEEP: assert property (exit_ctrl.port_a_clock_gate && exit_ctrl.port_b_clock_gate &&
		exit_ctrl.serial_clock_select == `SERIAL_CLOCK_SELECT)
		else $error("port gates or serial select lost");
	AST_FLASH_ALIGN: assert property (flash_req.valid && flash_req.op != boot_exec_pkg::FL_ERASE_ALL |->
		flash_req.addr[1:0] == 2'b00)
		else $error("unaligned flash word request");
	AST_FLASH_HOLD: assert property (flash_req.valid && !flash_done |=> $stable(flash_req))
		else $error("flash request changed before done");
	AST_VERY_LOW_POWER_RUN_ONCE: assert property (very_low_power_run_leave |-> $past(very_low_power_run) ##1
		!very_low_power_run_leave [*8])
		else $error("low power leave pulse wrong");
endmodule
bind boot_flash_command_executor boot_exec_checker u_chk (.*);

// ---- boot_flash_command_executor_tb.sv ----
// Testbench of the boot command executor with host, flash and RAM responders.
`timescale 1ns/1ns
`include "boot_exec_cfg.svh"
module boot_flash_command_executor_tb;
	logic ref_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, sector_protect = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_ack_o, cmd_ready, reply_ready, flash_done = 1'b0, flash_fail = 1'b0, ram_ack = 1'b0;
	logic detect_timeout = 1'b0, very_low_power_run = 1'b1, very_low_power_run_leave, chip_reset_req;
	logic secure_open, fv = 1'b0, rv = 1'b0, hs;
	logic [7:0] security_byte = 8'hFE;
	logic [63:0] backdoor_key = '0;
	logic [31:0] app_entry = 32'h0000_1001, app_stack = 32'h2000_0F00;
	boot_exec_pkg::byte_in_t cmd_in;
	boot_exec_pkg::generic_reply_t reply;
	boot_exec_pkg::flash_req_t flash_req;
	boot_exec_pkg::ram_req_t ram_req;
	boot_exec_pkg::jump_t jump, jl;
	boot_exec_pkg::exit_ctrl_t exit_ctrl;
	logic [65:0] fq[$];
	logic [39:0] rq[$];
	int njmp = 0, nrst = 0, nlv = 0, fails = 0, n_checks = 0;
	boot_flash_command_executor uut (.*);
	cmd_host host (.*);
	always #20 ref_clk = ~ref_clk;
	// ----------------------------------------------------------------
	// Responders and monitors
	// ----------------------------------------------------------------
	// Outputs are sampled at the falling edge so no read races the design's own update.
	always @(negedge ref_clk) begin
		fv = flash_req.valid && !flash_done;
		rv = ram_req.valid && !ram_ack;
		if (fv) fq.push_back({flash_req.op, flash_req.addr, flash_req.data});
		if (rv) rq.push_back({ram_req.addr, ram_req.data});
		if (jump.valid === 1'b1) begin
			jl = jump;
			hs = exit_ctrl.keep_high_speed;
			njmp++;
		end
		if (chip_reset_req === 1'b1) nrst++;
		if (very_low_power_run_leave === 1'b1) nlv++;
	end
	always @(posedge ref_clk) begin
		flash_done <= fv;
		ram_ack <= rv;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic run(input logic [7:0] code, input logic [7:0] pc, input logic [95:0] p, input logic [7:0] d[$],
		input logic [31:0] exp);
		logic [7:0] q[$];
		logic [31:0] st;
		q = '{code, 8'h00, 8'h00, pc};
		for (int i = 0; i < 4 * pc && i < 12; i++) q.push_back(p[8*i +: 8]);
		q = {q, d};
		host.send(q);
		host.get(st);
		chk("status", exp, st);
		chk("reply code", 32'(code), 32'(reply.command_code));
	endtask
	function automatic logic [31:0] fw(input logic [7:0] d[$], input int w);
		for (int k = 0; k < 4; k++) fw[8*k +: 8] = (4 * w + k < d.size()) ? d[4*w+k] : 8'hFF;
	endfunction
	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r, pc, arg, sp;
		logic [63:0] k;
		logic [7:0] d[$], none[$];
		r = $urandom(23);
		do_reset();
		wb(1'b0, 32'h0, 32'h0, r);
		chk("control", 32'(`CTRL_RESET), r);
		wb(1'b0, 32'hFC, 32'h0, r);
		chk("unmapped", 32'h0, r);
		wb(1'b1, 32'h0, 32'h3, r);
		wb(1'b0, 32'h0, 32'h0, r);
		chk("control", 32'h3, r);
		chk("gates", 32'h7, {exit_ctrl.port_a_clock_gate, exit_ctrl.port_b_clock_gate, 1'b1});
		chk("very_low_power_run", 1, nlv);
		$display("test registers done");
		run(8'h55, 8'h00, '0, none, `ST_UNKNOWN_CMD);
		run(`CMD_RESET, 8'h01, '0, none, `ST_INVALID_ARG);
		wb(1'b0, 32'h4, 32'h0, r);
		chk("status reg", `ST_INVALID_ARG, r);
		$display("test header done");
		k = {$urandom, $urandom};
		backdoor_key <= ~k;
		run(`CMD_KEY_UNLOCK, `PCNT_KEY_UNLOCK, {32'h0, k}, none, `ST_FLASH_FAIL);
		chk("secure", 0, secure_open);
		backdoor_key <= k;
		run(`CMD_KEY_UNLOCK, `PCNT_KEY_UNLOCK, {32'h0, k}, none, `ST_OK);
		chk("secure", 1, secure_open);
		$display("test key done");
		security_byte <= 8'h20;
		run(`CMD_ERASE_ALL_UNLOCK, 8'h00, '0, none, `ST_FLASH_FAIL);
		chk("no erase", 0, fq.size());
		security_byte <= 8'hFE;
		sector_protect <= '1;
		run(`CMD_ERASE_ALL_UNLOCK, 8'h00, '0, none, `ST_OK);
		chk("erase op", 32'(boot_exec_pkg::FL_ERASE_ALL), 32'(fq[0][65:64]));
		chk("sec addr", `SECURITY_LOCATION, fq[1][63:32]);
		chk("sec word", `SECURITY_WORD, fq[1][31:0]);
		$display("test erase done");
		sector_protect <= '0;
		fq.delete();
		repeat (5) d.push_back(8'($urandom));
		// Flash was mass erased above, as the host must do before storing.
		run(`CMD_MEM_STORE, `PCNT_MEM_STORE, {32'h0, 32'd5, 32'h0}, d, `ST_OK);
		chk("flash reqs", 4, fq.size());
		for (int w = 0; w < 2; w++) begin
			chk("op", 32'(boot_exec_pkg::FL_PROGRAM), 32'(fq[2*w][65:64]));
			chk("addr", 4 * w, fq[2*w][63:32]);
			chk("word", fw(d, w), fq[2*w][31:0]);
			chk("verify", 32'(boot_exec_pkg::FL_VERIFY), 32'(fq[2*w+1][65:64]));
		end
		run(`CMD_MEM_STORE, `PCNT_MEM_STORE, {32'h0, 32'd4, 32'h2}, none, `ST_FLASH_ALIGN);
		sector_protect <= 32'h0000_0002;
		run(`CMD_MEM_STORE, `PCNT_MEM_STORE, {32'h0, 32'd4, 32'h400}, none, `ST_FLASH_PROTECT);
		$display("test flash store done");
		d.delete();
		repeat (3) d.push_back(8'($urandom));
		run(`CMD_MEM_STORE, `PCNT_MEM_STORE, {32'h0, 32'd3, 32'h2000_0003}, d, `ST_OK);
		chk("ram reqs", 3, rq.size());
		foreach (d[i]) begin
			chk("ram addr", 32'h2000_0003 + 32'(i), rq[i][39:8]);
			chk("ram data", 32'(d[i]), 32'(rq[i][7:0]));
		end
		// A word that the flash refuses to take ends the store with a failure reply.
		d.push_back(8'h5A);
		flash_fail <= 1'b1;
		run(`CMD_MEM_STORE, `PCNT_MEM_STORE, {32'h0, 32'd4, 32'h800}, d, `ST_FLASH_FAIL);
		flash_fail <= 1'b0;
		$display("test ram store done");
		pc = $urandom;
		arg = $urandom;
		sp = $urandom & 32'hFFFF_FFFC;
		run(`CMD_EXECUTE, `PCNT_EXECUTE, {sp | 32'h1, arg, pc}, none, `ST_INVALID_ARG);
		chk("no jump", 0, njmp);
		run(`CMD_RESET, `PCNT_RESET, '0, none, `ST_OK);
		repeat (3) @(posedge ref_clk);
		chk("chip reset", 1, nrst);
		run(`CMD_EXECUTE, `PCNT_EXECUTE, {sp, arg, pc}, none, `ST_OK);
		repeat (4) @(posedge ref_clk);
		chk("jumps", 1, njmp);
		chk("pc", pc, jl.pc);
		chk("arg", arg, jl.arg);
		chk("sp", sp, jl.sp);
		chk("high speed", 1, hs);
		$display("test execute done");
		do_reset();
		// The idle executor leaves on every second cycle the timeout stands, so it is raised for one cycle only.
		detect_timeout <= 1'b1;
		@(posedge ref_clk);
		detect_timeout <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("jumps", 2, njmp);
		chk("app pc", app_entry, jl.pc);
		chk("app sp", app_stack, jl.sp);
		chk("app arg", 0, jl.arg);
		chk("very_low_power_run", 2, nlv);
		$display("test timeout done");
		tally_and_finish();
	end
endmodule

// ---- cmd_host.sv ----
// Host model: sends command bytes and accepts generic replies.
`timescale 1ns/1ns
module cmd_host (
	input wire logic ref_clk,
	input wire logic cmd_ready,
	input wire boot_exec_pkg::generic_reply_t reply,
	output boot_exec_pkg::byte_in_t cmd_in,
	output logic reply_ready
);
	initial begin
		cmd_in = '0;
		reply_ready = 1'b0;
	end
	// A released data line shows the inverse, so a stale byte is never mistaken for a fresh one.
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			cmd_in <= '{1'b1, q[i]};
			do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		end
		cmd_in <= '{1'b0, ~q[q.size()-1]};
	endtask
	// A slow host leaves the reply standing a few cycles before taking it.
	task automatic get(output logic [31:0] st);
		int n;
		n = 0;
		st = 'x;
		do begin
			@(negedge ref_clk);
			n++;
		end while (n < 3000 && reply.valid !== 1'b1);
		if (reply.valid === 1'b1) st = reply.status;
		repeat ($urandom % 3) @(posedge ref_clk);
		@(posedge ref_clk);
		reply_ready <= 1'b1;
		@(posedge ref_clk);
		reply_ready <= 1'b0;
	endtask
endmodule

// ---- word_lane_collector.sv ----
// Packs data bytes into a little-endian flash word whose unfilled lanes keep the erased value.
`timescale 1ns/1ns
`include "boot_exec_cfg.svh"
module word_lane_collector (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [7:0] data_in,
	output logic [31:0] word,
	output logic [2:0] count,
	output logic full
);
	boot_exec_pkg::lane_state_t s;
	boot_exec_pkg::lane_state_t next_s;

	always_comb begin
		next_s = s;
		if (clear) begin
			next_s.cnt = 3'h0;
			next_s.word = `ERASED_WORD;
		end else if (push && s.cnt != 3'h4) begin
			next_s.word[s.cnt[1:0]*8 +: 8] = data_in;
			next_s.cnt = s.cnt + 3'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '{cnt: 3'h0, word: `ERASED_WORD};
		end else begin
			s <= next_s;
		end
	end

	assign word = s.word;
	assign count = s.cnt;
	assign full = (s.cnt == 3'h4);
endmodule
